// ==== rtl/pdma_pkg.sv ====
// Purpose: shared constants for program and data memory addressing
// Assumes: one core clock, synchronous active-high reset
// Notes:   offsets are byte addresses on the plain register port
`default_nettype none
package pdma_pkg;
  // program side
  localparam int          PC_W        = 11;
  localparam int          PMEM_WORDS  = 2048;
  localparam int          INSTR_W     = 12;
  localparam int          STACK_DEPTH = 8;
  localparam int          PAGE_BITS   = 9;
  localparam logic [10:0] PC_RESET    = 11'h7FF;
  localparam logic [10:0] MASK_1PAGE  = 11'h1FF;
  localparam logic [10:0] MASK_2PAGE  = 11'h3FF;
  localparam logic [10:0] MASK_4PAGE  = 11'h7FF;
  // register port map
  localparam logic [7:0]  ADDR_PC_LOW = 8'h02;
  localparam logic [7:0]  ADDR_STATUS = 8'h03;
  localparam logic [7:0]  ADDR_POINTER  = 8'h04;
  localparam logic [7:0]  POINTER_RESET = 8'h00;
  localparam int          PAGE_LSB    = 5;
  localparam logic [2:0]  PAGE_RESET  = 3'h0;
  // data side
  localparam int          OPER_W      = 5;
  localparam int          BANK_LSB    = 5;
  localparam int          BANKED_BIT  = 4;
  localparam logic [7:0]  SFR_LAST    = 8'h07;
  localparam logic [7:0]  THIRD_PORT  = 8'h07;
  // fuse word layout
  localparam int          FUSE_SIZE_LSB  = 0;
  localparam int          FUSE_SMALL_BIT = 2;
  localparam logic [11:0] FUSE_RESET     = 12'h003;
  // programming port selects
  localparam logic [1:0]  PSEL_PMEM   = 2'h0;
  localparam logic [1:0]  PSEL_FUSE   = 2'h1;
  localparam logic [1:0]  PSEL_ID     = 2'h2;
  // memory size fuse codes
  typedef enum logic [1:0] {
    PDMA_CFG_P1B1 = 2'h0,
    PDMA_CFG_P2B1 = 2'h1,
    PDMA_CFG_P4B4 = 2'h2,
    PDMA_CFG_P4B8 = 2'h3
  } pdma_cfg_t;
endpackage : pdma_pkg
`default_nettype wire

// ==== rtl/pdma_stack.sv ====
// Purpose: eight-deep return address stack, shifting on push and pop
// Assumes: push and pop never asserted together
// Notes:   no data path reaches it except push and pop
`default_nettype none
module pdma_stack
  import pdma_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int W     = PC_W
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  output logic      [W-1:0] top
);
  logic [W-1:0] entry      [DEPTH];
  logic [W-1:0] next_entry [DEPTH];

  // each entry shifts down on push, up on pop
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_comb begin
      next_entry[i] = entry[i];
      if (push) begin
        next_entry[i] = (i == 0) ? push_data : entry[(i == 0) ? 0 : i - 1];
      end else if (pop) begin
        next_entry[i] = (i == DEPTH - 1) ? entry[i] : entry[(i == DEPTH - 1) ? i : i + 1];
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        entry[i] <= '0;
      end else begin
        entry[i] <= next_entry[i];
      end
    end
  end

  assign top = entry[0];
endmodule // pdma_stack
`default_nettype wire

// ==== rtl/pdma_top.sv ====
// Purpose: program counter, return stack and banked data addressing
// Assumes: execution logic gives one-cycle request pulses
// Notes:   fuse word and id word only via the programming port
//
// What this block does
// - program memory is 2K words of 12 bits, addressed by the counter
// - without a branch the counter counts up and wraps to zero
// - pages are 256 words; low eight counter bits index within a page
// - counting carries through page boundaries; pages shape branch targets and 02h writes only
// - counter is page-select bits above the low byte at 02h
// - reset loads the counter with the highest address
// - eight 11-bit return entries; call pushes, return pops
// - return stack is not reachable as data
// - 136 general bytes: eight banks of 16 plus eight unbanked
// - direct operands carry five address bits, 00h to 1Fh
// - pointer at 04h: top three bits bank, low five bits location
// - addresses with bit 4 clear always go to bank 0
// - small package: address 07h becomes a general RAM byte
// - hard-wired 12-bit identification word, read only
// - fuse word read and programmed only through the programming port
`default_nettype none
module pdma_top
  import pdma_pkg::*;
#(
  parameter logic [11:0] DEVICE_ID = 12'h5A3 // arbitrary value
) (
  input  wire logic                core_clk,
  input  wire logic                srst,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  // execution requests
  input  wire logic                exec_advance,
  input  wire logic                exec_jump,
  input  wire logic                exec_call,
  input  wire logic                exec_ret,
  input  wire logic [7:0]          exec_target,
  input  wire logic                exec_page_load,
  input  wire logic [2:0]          exec_page,
  output logic      [PC_W-1:0]     instr_addr,
  output logic      [INSTR_W-1:0]  instr_word,
  // operand addressing
  input  wire logic                op_req,
  input  wire logic                op_indirect,
  input  wire logic [OPER_W-1:0]   op_addr,
  output logic      [7:0]          ram_addr,
  output logic                     ram_is_sfr,
  output logic                     ram_valid,
  // programming port
  input  wire logic                prog_wr,
  input  wire logic                prog_rd,
  input  wire logic [1:0]          prog_sel,
  input  wire logic [PC_W-1:0]     prog_addr,
  input  wire logic [INSTR_W-1:0]  prog_wdata,
  output logic      [INSTR_W-1:0]  prog_rdata
);
  logic [PC_W-1:0]    pc;
  logic [PC_W-1:0]    next_pc;
  logic [2:0]         page_select;
  logic [2:0]         next_page_select;
  logic [7:0]         file_select_pointer;
  logic [7:0]         next_file_select_pointer;
  logic [11:0]        extended_fuse_word;
  logic [11:0]        next_extended_fuse_word;
  logic [7:0]         next_reg_rdata;
  logic [INSTR_W-1:0] next_prog_rdata;
  logic [7:0]         next_ram_addr;
  logic               next_ram_is_sfr;
  logic [PC_W-1:0]    prog_mask;
  logic [2:0]         bank_mask;
  logic [PC_W-1:0]    ret_addr;
  logic [PC_W-1:0]    far_target;
  logic [PC_W-1:0]    seq_pc;
  logic [PC_W-1:0]    instr_addr_stack_top;
  logic [OPER_W-1:0]  eff_addr;
  logic [2:0]         bank;
  logic [1:0]         memory_size_fuse;
  logic               small_package;
  logic               do_push;
  logic               do_pop;
  logic [INSTR_W-1:0] pmem [PMEM_WORDS];

  assign memory_size_fuse = extended_fuse_word[FUSE_SIZE_LSB +: 2];
  assign small_package    = extended_fuse_word[FUSE_SMALL_BIT];

  // fuse code to program mask and bank mask
  always_comb begin
    prog_mask = MASK_4PAGE;
    bank_mask = 3'h7;
    case (pdma_cfg_t'(memory_size_fuse))
      PDMA_CFG_P1B1: begin
        prog_mask = MASK_1PAGE;
        bank_mask = 3'h0;
      end
      PDMA_CFG_P2B1: begin
        prog_mask = MASK_2PAGE;
        bank_mask = 3'h0;
      end
      PDMA_CFG_P4B4: begin
        prog_mask = MASK_4PAGE;
        bank_mask = 3'h3;
      end
      default: begin
        prog_mask = MASK_4PAGE;
        bank_mask = 3'h7;
      end
    endcase
  end

  // branch target and sequential address
  assign far_target = {page_select, exec_target} & prog_mask;
  assign seq_pc     = (pc + 11'h001) & prog_mask;
  assign ret_addr   = seq_pc;
  assign do_push    = exec_call;
  assign do_pop     = exec_ret & ~exec_call;

  // return stack, no register address maps onto it
  pdma_stack #(
    .DEPTH (STACK_DEPTH),
    .W     (PC_W)
  ) u_stack (
    .core_clk  (core_clk),
    .srst      (srst),
    .push      (do_push),
    .pop       (do_pop),
    .push_data (ret_addr),
    .top       (instr_addr_stack_top)
  );

  // counter: call or jump, return, port write, advance
  always_comb begin
    next_pc = pc;
    if (exec_call || exec_jump) begin
      next_pc = far_target;
    end else if (exec_ret) begin
      next_pc = instr_addr_stack_top;
    end else if (reg_wr && reg_addr == ADDR_PC_LOW) begin
      next_pc = {page_select, reg_wdata} & prog_mask;
    end else if (exec_advance) begin
      next_pc = seq_pc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  assign instr_addr = pc;

  // page bits and pointer from port or page preset
  always_comb begin
    next_page_select         = page_select;
    next_file_select_pointer = file_select_pointer;
    if (exec_page_load) begin
      next_page_select = exec_page;
    end else if (reg_wr && reg_addr == ADDR_STATUS) begin
      next_page_select = reg_wdata[PAGE_LSB +: 3];
    end
    if (reg_wr && reg_addr == ADDR_POINTER) begin
      next_file_select_pointer = reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      page_select         <= PAGE_RESET;
      file_select_pointer <= POINTER_RESET;
    end else begin
      page_select         <= next_page_select;
      file_select_pointer <= next_file_select_pointer;
    end
  end

  // register read data, one cycle after the strobe
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ADDR_PC_LOW) begin
        next_reg_rdata = pc[7:0];
      end else if (reg_addr == ADDR_STATUS) begin
        next_reg_rdata = {page_select, 5'h00};
      end else if (reg_addr == ADDR_POINTER) begin
        next_reg_rdata = file_select_pointer;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // operand to physical ram index: 0..15 global, 16..143 banked
  assign eff_addr = op_indirect ? file_select_pointer[OPER_W-1:0] : op_addr;
  assign bank     = file_select_pointer[BANK_LSB +: 3] & bank_mask;

  always_comb begin
    next_ram_addr   = ram_addr;
    next_ram_is_sfr = ram_is_sfr;
    if (op_req) begin
      if (!eff_addr[BANKED_BIT]) begin
        next_ram_addr = {4'h0, eff_addr[3:0]};
      end else begin
        next_ram_addr = {bank, eff_addr[3:0]} + 8'h10;
      end
      next_ram_is_sfr = (next_ram_addr <= SFR_LAST) &&
                        !(small_package && next_ram_addr == THIRD_PORT);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ram_addr   <= 8'h00;
      ram_is_sfr <= 1'b0;
      ram_valid  <= 1'b0;
    end else begin
      ram_addr   <= next_ram_addr;
      ram_is_sfr <= next_ram_is_sfr;
      ram_valid  <= op_req;
    end
  end

  // fuse word: programming port only
  always_comb begin
    next_extended_fuse_word = extended_fuse_word;
    if (prog_wr && prog_sel == PSEL_FUSE) begin
      next_extended_fuse_word = prog_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      extended_fuse_word <= FUSE_RESET;
    end else begin
      extended_fuse_word <= next_extended_fuse_word;
    end
  end

  // programming reads: memory, fuse word, fixed id
  always_comb begin
    next_prog_rdata = '0;
    if (prog_rd) begin
      if (prog_sel == PSEL_PMEM) begin
        next_prog_rdata = pmem[prog_addr];
      end else if (prog_sel == PSEL_FUSE) begin
        next_prog_rdata = extended_fuse_word;
      end else if (prog_sel == PSEL_ID) begin
        next_prog_rdata = DEVICE_ID;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prog_rdata <= '0;
      instr_word <= '0;
    end else begin
      prog_rdata <= next_prog_rdata;
      instr_word <= pmem[pc];
    end
  end

  // program memory array, written only by programming
  always_ff @(posedge core_clk) begin
    if (prog_wr && prog_sel == PSEL_PMEM) begin
      pmem[prog_addr] <= prog_wdata;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic solo_adv;
  assign solo_adv = exec_advance && !exec_call && !exec_jump && !exec_ret &&
                    !(reg_wr && reg_addr == ADDR_PC_LOW);

  reset_top_a: assert property (@(posedge core_clk) $fell(srst) |-> pc == PC_RESET)
    else $error("counter not at top after reset");
  count_up_a: assert property (solo_adv |=> pc == (($past(pc) + 11'h001) & $past(prog_mask)))
    else $error("counter did not advance by one");
  wrap_zero_a: assert property (solo_adv && pc == PC_RESET && prog_mask == MASK_4PAGE |=> pc == 11'h000)
    else $error("counter did not wrap to zero");
  far_jump_a: assert property (exec_jump && !exec_call |=> pc == ({$past(page_select), $past(exec_target)} & $past(prog_mask)))
    else $error("jump target not page plus low byte");
  call_ret_a: assert property (exec_call ##1 (exec_ret && !exec_call) |=> pc == (($past(pc, 2) + 11'h001) & $past(prog_mask, 2)))
    else $error("return did not restore address");
  global_low_a: assert property (op_req && !eff_addr[BANKED_BIT] |=> ram_addr == {4'h0, $past(eff_addr[3:0])})
    else $error("low address left bank 0");
  bank_pick_a: assert property (op_req && eff_addr[BANKED_BIT] |=> ram_addr[7:4] == {1'b0, $past(bank)} + 4'h1)
    else $error("banked address wrong bank");
  third_port_a: assert property (op_req && eff_addr == 5'h07 |=> ram_is_sfr == !$past(small_package))
    else $error("07h mapping wrong for package");
  id_read_a: assert property (prog_rd && prog_sel == PSEL_ID |=> prog_rdata == DEVICE_ID)
    else $error("id word read wrong");
  fuse_guard_a: assert property (!(prog_wr && prog_sel == PSEL_FUSE) |=> $stable(extended_fuse_word))
    else $error("fuse word changed without programming");

  call_then_ret_c: cover property (exec_call ##1 exec_ret);
  wrap_seen_c: cover property (solo_adv && pc == PC_RESET);
  banked_ind_c: cover property (op_req && op_indirect && eff_addr[BANKED_BIT] && bank != 3'h0);
endmodule // pdma_top
`default_nettype wire

// ==== tb/pdma_exec_model.sv ====
// Purpose: stand-in for the core execution logic driving branch requests
// Assumes: one request at a time, each a one-cycle pulse
// Notes:   tasks are called from the bench; strobes idle low, target and page keep their last value
`default_nettype none
module pdma_exec_model
  import pdma_pkg::*;
(
  input  wire logic       core_clk,
  output logic            exec_advance,
  output logic            exec_jump,
  output logic            exec_call,
  output logic            exec_ret,
  output logic [7:0]      exec_target,
  output logic            exec_page_load,
  output logic [2:0]      exec_page
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels from time zero
  initial begin
    {exec_advance, exec_jump, exec_call, exec_ret, exec_page_load} = 5'h00;
    exec_target = 8'h00;
    exec_page   = 3'h0;
  end

  // kind: 0 advance, 1 jump, 2 call, 3 return; pulse lasts one cycle
  task automatic issue(input int kind, input logic [7:0] tgt);
    @(posedge core_clk);
    exec_advance <= (kind == 0);
    exec_jump    <= (kind == 1);
    exec_call    <= (kind == 2);
    exec_ret     <= (kind == 3);
    exec_target  <= tgt;
    @(posedge core_clk);
    {exec_advance, exec_jump, exec_call, exec_ret} <= 4'h0;
  endtask

  // call followed at once by a return, no idle cycle between
  task automatic call_ret(input logic [7:0] tgt);
    @(posedge core_clk);
    exec_call   <= 1'b1;
    exec_target <= tgt;
    @(posedge core_clk);
    exec_call <= 1'b0;
    exec_ret  <= 1'b1;
    @(posedge core_clk);
    exec_ret <= 1'b0;
  endtask

  // page preset before any far branch or call
  task automatic page(input logic [2:0] p);
    @(posedge core_clk);
    exec_page_load <= 1'b1;
    exec_page      <= p;
    @(posedge core_clk);
    exec_page_load <= 1'b0;
  endtask
endmodule // pdma_exec_model
`default_nettype wire

// ==== tb/pdma_top_tb.sv ====
// Purpose: self-checking bench for counter, stack and data addressing
// Assumes: default fuse word at reset, identification word set to ID_WORD
// Notes:   expectations come from the documented behaviour only
`default_nettype none
module pdma_top_tb
  import pdma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk, srst;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata;
  logic               reg_wr, reg_rd;
  logic               exec_advance, exec_jump, exec_call, exec_ret, exec_page_load;
  logic [7:0]         exec_target;
  logic [2:0]         exec_page;
  logic [PC_W-1:0]    instr_addr, prog_addr;
  logic [INSTR_W-1:0] instr_word, prog_wdata, prog_rdata;
  logic               op_req, op_indirect, ram_is_sfr, ram_valid, prog_wr, prog_rd;
  logic [OPER_W-1:0]  op_addr;
  logic [7:0]         ram_addr;
  logic [1:0]         prog_sel;
  int                 n_errors, check_count;
  logic [10:0]        ret_q[$];
  logic [10:0]        masks[4] = '{11'h1FF, 11'h3FF, 11'h7FF, 11'h7FF};
  logic [7:0]         banks[4] = '{8'h10, 8'h10, 8'h40, 8'h80};
  localparam logic [11:0] ID_WORD = 12'h3C6; // arbitrary value

  pdma_top #(
    .DEVICE_ID (ID_WORD)
  ) i_pdma_top (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_advance(exec_advance),
    .exec_jump(exec_jump), .exec_call(exec_call), .exec_ret(exec_ret), .exec_target(exec_target),
    .exec_page_load(exec_page_load), .exec_page(exec_page), .instr_addr(instr_addr),
    .instr_word(instr_word), .op_req(op_req), .op_indirect(op_indirect), .op_addr(op_addr),
    .ram_addr(ram_addr), .ram_is_sfr(ram_is_sfr), .ram_valid(ram_valid), .prog_wr(prog_wr),
    .prog_rd(prog_rd), .prog_sel(prog_sel), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_rdata(prog_rdata));

  pdma_exec_model i_pdma_exec_model (.core_clk(core_clk), .exec_advance(exec_advance),
    .exec_jump(exec_jump), .exec_call(exec_call), .exec_ret(exec_ret), .exec_target(exec_target),
    .exec_page_load(exec_page_load), .exec_page(exec_page));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // register port write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // register port read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // operand request, result one cycle later
  task automatic op(input logic ind, input logic [4:0] a, input logic [7:0] exp, input logic sfr);
    @(posedge core_clk);
    op_req <= 1'b1; op_indirect <= ind; op_addr <= a;
    @(posedge core_clk);
    op_req <= 1'b0;
    #1 chk("ram_valid", {15'h0, ram_valid}, 16'h0001);
    chk("ram_addr", {8'h00, ram_addr}, {8'h00, exp});
    chk("ram_is_sfr", {15'h0, ram_is_sfr}, {15'h0, sfr});
  endtask

  // programming port access; a read checks the returned word
  task automatic prog(input logic w, input logic [1:0] s, input logic [10:0] a, input logic [11:0] d);
    @(posedge core_clk);
    prog_wr <= w; prog_rd <= ~w; prog_sel <= s; prog_addr <= a; prog_wdata <= d;
    @(posedge core_clk);
    {prog_wr, prog_rd} <= 2'h0;
    #1 if (!w) chk("prog_rdata", {4'h0, prog_rdata}, {4'h0, d});
  endtask

  task automatic pc_is(input logic [10:0] exp);
    #1 chk("instr_addr", {5'h00, instr_addr}, {5'h00, exp});
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize();
  end

  // main sequence
  initial begin
    n_errors = 0; check_count = 0; srst = 1'b1;
    {reg_wr, reg_rd, op_req, op_indirect, prog_wr, prog_rd} = 6'h00;
    reg_addr = 8'h00; reg_wdata = 8'h00; op_addr = 5'h00; prog_sel = 2'h0;
    prog_addr = 11'h000; prog_wdata = 12'h000;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    pc_is(11'h7FF);
    rd(8'h04, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h02, 8'hFF);
    i_pdma_exec_model.issue(0, 8'h00);
    pc_is(11'h000);
    wr(8'h04, 8'h90);
    rd(8'h04, 8'h90);
    // page boundary crossing by plain advance
    i_pdma_exec_model.page(3'h1);
    wr(8'h02, 8'hFF);
    pc_is(11'h1FF);
    i_pdma_exec_model.issue(0, 8'h00);
    pc_is(11'h200);
    rd(8'h02, 8'h00);
    // eight nested calls then eight returns
    i_pdma_exec_model.page(3'h2);
    for (int k = 0; k < 8; k++) begin
      ret_q.push_back(instr_addr + 11'h001);
      i_pdma_exec_model.issue(2, 8'h10 + 8'(k));
      pc_is(11'h210 + 11'(k));
    end
    for (int k = 0; k < 8; k++) begin
      i_pdma_exec_model.issue(3, 8'h00);
      pc_is(ret_q.pop_back());
    end
    // call and return on consecutive cycles
    i_pdma_exec_model.call_ret(8'h40);
    pc_is(11'h202);
    // direct and indirect operand mapping, pointer bank 4
    op(1'b0, 5'h10, 8'h50, 1'b0);
    op(1'b0, 5'h05, 8'h05, 1'b1);
    op(1'b0, 5'h07, 8'h07, 1'b1);
    op(1'b1, 5'h00, 8'h50, 1'b0);
    wr(8'h04, 8'h8F);
    op(1'b1, 5'h00, 8'h0F, 1'b0);
    // identification and fuse words via programming port only
    prog(1'b0, 2'h2, 11'h000, ID_WORD);
    prog(1'b1, 2'h2, 11'h000, 12'h000);
    prog(1'b0, 2'h2, 11'h000, ID_WORD);
    prog(1'b0, 2'h1, 11'h000, 12'h003);
    // program memory word fetched at the counter
    prog(1'b1, 2'h0, 11'h123, 12'hABC);
    prog(1'b0, 2'h0, 11'h123, 12'hABC);
    i_pdma_exec_model.page(3'h1);
    i_pdma_exec_model.issue(1, 8'h23);
    pc_is(11'h123);
    @(posedge core_clk);
    #1 chk("instr_word", {4'h0, instr_word}, 16'h0ABC);
    // every memory size code: jump to the top of page 7, wrap and bank
    for (int c = 0; c < 4; c++) begin
      prog(1'b1, 2'h1, 11'h000, 12'(c));
      wr(8'h04, 8'hE0);
      i_pdma_exec_model.page(3'h7);
      i_pdma_exec_model.issue(1, 8'hFF);
      pc_is(masks[c]);
      i_pdma_exec_model.issue(0, 8'h00);
      pc_is(11'h000);
      op(1'b0, 5'h10, banks[c], 1'b0);
    end
    // small package frees address 07h
    prog(1'b1, 2'h1, 11'h000, 12'h007);
    op(1'b0, 5'h07, 8'h07, 1'b0);
    summarize();
  end
endmodule // pdma_top_tb
`default_nettype wire
